// ===== bit_test_modify_datapath.sv
// execution datapath for the bit test-and-clear and test-and-set instructions
`timescale 1ns/1ps
`default_nettype none
`include "bit_test_defs.svh"

module bit_test_modify_datapath
    import bit_test_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_load,
    input var arch_regs_t i_load_regs,
    input wire logic i_state4,
    input var instr_t i_instr,
    input wire logic [4:0] i_index_value,
    output arch_regs_t o_regs,
    output logic o_test_flag,
    output logic [4:0] o_tally,
    output logic o_busy,
    output logic o_done
);

    seq_state_t state;
    op_kind_t op_kind;
    logic [4:0] rot_count;
    logic adder_carry_flop;
    logic adder_sum;
    logic adder_carry_out;
    logic adder_b;
    logic tally_terminal_match;
    logic accumulator_shift_right;
    logic op_valid;
    logic start;
    logic [4:0] target_bit;

    function automatic logic is_bit_op(input instr_t ins);
        is_bit_op = (ins.opcode == `OPCODE_GENERAL) && !ins.mode &&
            ((ins.subop == `SUBOP_CLEAR) || (ins.subop == `SUBOP_FORCE_ONE));
    endfunction

    function automatic logic [4:0] form_bit_num(input instr_t ins, input logic [4:0] idx);
        form_bit_num = (ins.index_sel == 3'h0) ? ins.bit_num : 5'(ins.bit_num + idx);
    endfunction

    function automatic logic [23:0] bit_mask(input logic [4:0] z);
        bit_mask = 24'h00_0001 << z;
    endfunction

    always_comb begin
        op_valid = is_bit_op(i_instr);
        target_bit = form_bit_num(i_instr, i_index_value);
        start = i_state4 && (state == st_idle) && op_valid;
        accumulator_shift_right = (state == st_rotate);
        tally_terminal_match = (o_tally == `TALLY_TERMINAL);
    end

    // second adder input, disabled except at the terminal tally
    always_comb begin
        adder_b = 1'b0;
        if (accumulator_shift_right && tally_terminal_match) begin
            if (op_kind == zero_probe_and_clear_op) begin
                adder_b = o_regs.acc[0];
            end else begin
                adder_b = ~o_regs.acc[0];
            end
        end
    end

    serial_bit_adder u_adder (
        .i_a(o_regs.acc[0]),
        .i_b(adder_b),
        .i_carry(adder_carry_flop),
        .o_sum(adder_sum),
        .o_carry(adder_carry_out)
    );

    // carry held clear for these instructions, so it never holds a carry
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            adder_carry_flop <= 1'b0;
        end else if (accumulator_shift_right || start) begin
            adder_carry_flop <= 1'b0;
        end else begin
            adder_carry_flop <= adder_carry_out & 1'b0;
        end
    end

    // sequencing
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state <= st_idle;
            op_kind <= zero_probe_and_clear_op;
            rot_count <= 5'h00;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state)
                st_idle: begin
                    if (start) begin
                        state <= st_rotate;
                        op_kind <= (i_instr.subop == `SUBOP_FORCE_ONE) ?
                            zero_probe_and_force_one_op : zero_probe_and_clear_op;
                        rot_count <= 5'h00;
                        o_busy <= 1'b1;
                    end
                end
                st_rotate: begin
                    rot_count <= 5'(rot_count + 5'h01);
                    if (rot_count == `ROT_LAST) begin
                        state <= st_idle;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                    end
                end
                default: begin
                    state <= st_idle;
                    o_busy <= 1'b0;
                end
            endcase
        end
    end

    // shift tally
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_tally <= 5'h00;
        end else if (start) begin
            o_tally <= ~target_bit;
        end else if (accumulator_shift_right) begin
            o_tally <= 5'(o_tally + 5'h01);
        end
    end

    // test flag
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_test_flag <= 1'b0;
        end else if (start) begin
            o_test_flag <= 1'b1;
        end else if (accumulator_shift_right && tally_terminal_match && o_regs.acc[0]) begin
            o_test_flag <= 1'b0;
        end
    end

    // accumulator, secondary register and program counter
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_regs <= '0;
        end else if (accumulator_shift_right) begin
            o_regs.acc <= {adder_sum, o_regs.acc[23:1]};
            if (rot_count == `ROT_LAST) begin
                o_regs.pc <= 15'(o_regs.pc + 15'h0001);
            end
        end else if (i_load && !start) begin
            o_regs <= i_load_regs;
        end
    end

    // checking helpers: capture the operands at the start
    logic [23:0] orig_acc;
    logic [23:0] orig_q;
    logic [14:0] orig_pc;
    logic [4:0] orig_z;
    logic orig_bit;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            orig_acc <= 24'h00_0000;
            orig_q <= 24'h00_0000;
            orig_pc <= 15'h0000;
            orig_z <= 5'h00;
            orig_bit <= 1'b0;
        end else if (start) begin
            orig_acc <= o_regs.acc;
            orig_q <= o_regs.q;
            orig_pc <= o_regs.pc;
            orig_z <= target_bit;
            orig_bit <= (target_bit <= `ACC_TOP_BIT) ? o_regs.acc[target_bit] : 1'b0;
        end
    end

    // counts the busy cycles of one rotation for the span check
    logic [4:0] span_count;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            span_count <= 5'h00;
        end else if (start) begin
            span_count <= 5'h00;
        end else if (o_busy) begin
            span_count <= 5'(span_count + 5'h01);
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking

    default disable iff (i_rst);

    flag_forced_set_a: assert property (
        start |=> o_test_flag && o_busy)
        else $error("test flag not set after state 4");

    tally_preload_a: assert property (
        start |=> o_tally == ~$past(target_bit))
        else $error("tally not loaded with complemented bit number");

    tally_counts_a: assert property (
        accumulator_shift_right |=> o_tally == 5'($past(o_tally) + 5'h01))
        else $error("tally did not count on a shift");

    plain_rotate_a: assert property (
        accumulator_shift_right && !tally_terminal_match |=>
            o_regs.acc == {$past(o_regs.acc[0]), $past(o_regs.acc[23:1])})
        else $error("rotation altered an untouched bit");

    clear_write_a: assert property (
        accumulator_shift_right && tally_terminal_match &&
            op_kind == zero_probe_and_clear_op |=> !o_regs.acc[23])
        else $error("clear variant did not write zero");

    force_write_a: assert property (
        accumulator_shift_right && tally_terminal_match &&
            op_kind == zero_probe_and_force_one_op |=> o_regs.acc[23])
        else $error("set variant did not write one");

    flag_probe_a: assert property (
        accumulator_shift_right && tally_terminal_match |=>
            o_test_flag == !$past(o_regs.acc[0]))
        else $error("test flag wrong after the probed bit");

    full_rotation_a: assert property (
        start |=> o_busy [*8] ##16 o_busy ##1 (o_done && !o_busy))
        else $error("rotation did not last 24 places");

    clear_result_a: assert property (
        o_done && op_kind == zero_probe_and_clear_op && orig_z <= `ACC_TOP_BIT |->
            o_regs.acc == (orig_acc & ~bit_mask(orig_z)) && o_test_flag == !orig_bit)
        else $error("clear variant result wrong");

    force_result_a: assert property (
        o_done && op_kind == zero_probe_and_force_one_op && orig_z <= `ACC_TOP_BIT |->
            o_regs.acc == (orig_acc | bit_mask(orig_z)) && o_test_flag == !orig_bit)
        else $error("set variant result wrong");

    out_of_range_a: assert property (
        o_done && orig_z > `ACC_TOP_BIT |-> o_test_flag && o_regs.acc == orig_acc)
        else $error("out of range bit number disturbed flag or accumulator");

    pc_advance_a: assert property (
        o_done |-> o_regs.pc == 15'(orig_pc + 15'h0001) && o_regs.q == orig_q)
        else $error("program counter or secondary register wrong at completion");

    final_tally_a: assert property (
        o_done |-> o_tally == 5'(~orig_z + `ROT_PLACES))
        else $error("tally not at its final value");

    busy_span_a: assert property (
        o_done |-> span_count == `ROT_PLACES)
        else $error("busy did not last 24 cycles");

    bad_code_ignored_a: assert property (
        i_state4 && !o_busy &&
            (i_instr.opcode != `OPCODE_GENERAL || i_instr.mode) |=> !o_busy)
        else $error("a foreign instruction started the rotation");

    q_held_a: assert property (
        accumulator_shift_right |=> $stable(o_regs.q))
        else $error("secondary register changed during rotation");

    flag_held_a: assert property (
        accumulator_shift_right && !tally_terminal_match |=> $stable(o_test_flag))
        else $error("test flag moved away from the probed shift");

    clear_done_c: cover property (
        o_done && op_kind == zero_probe_and_clear_op && orig_z <= `ACC_TOP_BIT);

    force_done_c: cover property (
        o_done && op_kind == zero_probe_and_force_one_op && orig_bit);

    range_done_c: cover property (o_done && orig_z > `ACC_TOP_BIT);

    busy_refuse_c: cover property (o_busy && i_state4);

endmodule

`default_nettype wire

// ===== bit_test_defs.svh
// constants for the bit test-and-modify datapath
`ifndef BIT_TEST_DEFS_SVH
`define BIT_TEST_DEFS_SVH

`define ACC_WIDTH 24
`define PC_WIDTH 15
`define TALLY_WIDTH 5
`define ROT_COUNT_WIDTH 5

// instruction word fields
`define OPCODE_HI 23
`define OPCODE_LO 18
`define INDEX_HI 17
`define INDEX_LO 15
`define SUBOP_HI 14
`define SUBOP_LO 6
`define MODE_BIT 5
`define BITNUM_HI 4
`define BITNUM_LO 0

// operation codes
`define OPCODE_GENERAL 6'h05
`define SUBOP_CLEAR 9'h012E
`define SUBOP_FORCE_ONE 9'h0136

// tally and rotation figures
`define TALLY_TERMINAL 5'h1F
`define ROT_PLACES 5'h18
`define ROT_LAST 5'h17
`define ACC_TOP_BIT 5'h17

`endif

// ===== bit_test_pkg.sv
// types for the bit test-and-modify datapath
package bit_test_pkg;

    typedef enum logic {
        zero_probe_and_clear_op = 1'b0,
        zero_probe_and_force_one_op = 1'b1
    } op_kind_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_rotate = 2'b01
    } seq_state_t;

    typedef struct packed {
        logic [5:0] opcode;
        logic [2:0] index_sel;
        logic [8:0] subop;
        logic mode;
        logic [4:0] bit_num;
    } instr_t;

    typedef struct packed {
        logic [23:0] acc;
        logic [23:0] q;
        logic [14:0] pc;
    } arch_regs_t;

endpackage

// ===== serial_bit_adder.sv
// one-bit serial full adder used by the accumulator rotation
`timescale 1ns/1ps
`default_nettype none

module serial_bit_adder (
    input wire logic i_a,
    input wire logic i_b,
    input wire logic i_carry,
    output logic o_sum,
    output logic o_carry
);

    always_comb begin
        o_sum = i_a ^ i_b ^ i_carry;
        o_carry = (i_a & i_b) | (i_a & i_carry) | (i_b & i_carry);
    end

endmodule

`default_nettype wire

// ===== instr_sequencer_model.sv
// behavioural instruction sequencer that feeds the datapath
`timescale 1ns/1ps
`default_nettype none
module instr_sequencer_model
    import bit_test_pkg::*;
(
    input wire logic i_clk_sys,
    output var logic o_load,
    output var arch_regs_t o_load_regs,
    output var logic o_state4,
    output var instr_t o_instr,
    output var logic [4:0] o_index_value
);
    initial begin
        o_load = 1'b0;
        o_load_regs = '0;
        o_state4 = 1'b0;
        o_instr = '0;
        o_index_value = 5'h00;
    end
    // present registers for one edge, then scramble the released lines
    task automatic load(input arch_regs_t regs);
        @(negedge i_clk_sys);
        o_load = 1'b1;
        o_load_regs = regs;
        @(negedge i_clk_sys);
        o_load = 1'b0;
        o_load_regs = ~regs;
    endtask
    // one-cycle state 4 pulse with the decoded word valid
    task automatic start(input instr_t ins, input logic [4:0] idx);
        @(negedge i_clk_sys);
        o_state4 = 1'b1;
        o_instr = ins;
        o_index_value = idx;
        @(negedge i_clk_sys);
        o_state4 = 1'b0;
        o_instr = ~ins;
        o_index_value = ~idx;
    endtask
endmodule
`default_nettype wire

// ===== bit_test_modify_datapath_bench.sv
// self-checking bench for the bit test-and-modify datapath
`timescale 1ns/1ps
`default_nettype none
`include "bit_test_defs.svh"
`define CHECK(nm, e, g) check(nm, 72'(e), 72'(g))
module bit_test_modify_datapath_bench
    import bit_test_pkg::*;
;
    typedef struct packed {
        arch_regs_t regs;
        logic flag;
        logic [4:0] tally;
    } expect_t;
    logic i_clk_sys;
    logic i_rst;
    logic load;
    arch_regs_t load_regs;
    logic state4;
    instr_t instr;
    logic [4:0] index_value;
    arch_regs_t o_regs;
    logic o_test_flag;
    logic [4:0] o_tally;
    logic o_busy;
    logic o_done;
    expect_t notes[$];
    expect_t seen;
    int busy_n = 0;
    int mismatches = 0;
    int n_tests = 0;
    logic [4:0] zs [6] = '{5'h00, 5'h01, 5'h16, 5'h17, 5'h18, 5'h1F};
    instr_t bad [3] = '{
        '{`OPCODE_GENERAL, 3'h0, `SUBOP_CLEAR, 1'b1, 5'h03},
        '{6'h06, 3'h0, `SUBOP_FORCE_ONE, 1'b0, 5'h03},
        '{`OPCODE_GENERAL, 3'h0, 9'h000, 1'b0, 5'h03}};

    instr_sequencer_model i_seq (.i_clk_sys(i_clk_sys), .o_load(load), .o_load_regs(load_regs),
        .o_state4(state4), .o_instr(instr), .o_index_value(index_value));
    bit_test_modify_datapath i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_load(load),
        .i_load_regs(load_regs), .i_state4(state4), .i_instr(instr),
        .i_index_value(index_value), .o_regs(o_regs), .o_test_flag(o_test_flag),
        .o_tally(o_tally), .o_busy(o_busy), .o_done(o_done));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input string nm, input logic [71:0] e, input logic [71:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watcher: takes the oldest note whenever a completion appears
    always @(negedge i_clk_sys) begin
        if (o_busy === 1'b1)
            busy_n++;
        if (o_done === 1'b1) begin
            if (notes.size() == 0)
                `CHECK("spare done", 1'b0, 1'b1);
            else begin
                seen = notes.pop_front();
                `CHECK("acc", seen.regs.acc, o_regs.acc);
                `CHECK("q and pc", {seen.regs.q, seen.regs.pc}, {o_regs.q, o_regs.pc});
                `CHECK("test flag", seen.flag, o_test_flag);
                `CHECK("tally", seen.tally, o_tally);
                `CHECK("busy cycles", 24, busy_n);
            end
            busy_n = 0;
        end
    end

    task automatic run(input op_kind_t op, input logic [2:0] xs, input logic [4:0] k,
                       input logic [4:0] idx, input logic bump);
        instr_t ins;
        expect_t ex;
        logic [4:0] z;
        ins = '{`OPCODE_GENERAL, xs, (op == zero_probe_and_clear_op) ? `SUBOP_CLEAR
            : `SUBOP_FORCE_ONE, 1'b0, k};
        ex.regs = {24'($urandom), 24'($urandom), 15'($urandom)};
        i_seq.load(ex.regs);
        z = (xs == 3'h0) ? k : k + idx;
        ex.regs.pc = ex.regs.pc + 15'h0001;
        ex.flag = 1'b1;
        ex.tally = ~z + 5'h18;
        if (z <= `ACC_TOP_BIT) begin
            ex.flag = ~ex.regs.acc[z];
            ex.regs.acc[z] = (op == zero_probe_and_force_one_op);
        end
        notes.push_back(ex);
        i_seq.start(ins, idx);
        if (bump) begin
            i_seq.load(~ex.regs);
            repeat (3) @(negedge i_clk_sys);
            ins.subop = ins.subop ^ `SUBOP_CLEAR ^ `SUBOP_FORCE_ONE;
            i_seq.start(ins, ~idx);
        end
        for (int n = 0; n < 40 && notes.size() > 0; n++)
            @(negedge i_clk_sys);
        @(posedge i_clk_sys);
        `CHECK("done seen", 1'b1, notes.size() == 0);
    endtask

    initial begin
        void'($urandom(32'h5649_dc62));
        i_rst = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst = 1'b0;
        `CHECK("reset state", 72'h0, {o_regs, o_test_flag, o_tally, o_busy, o_done});
        foreach (zs[j])
            for (int o = 0; o < 2; o++)
                run(op_kind_t'(o), 3'h0, zs[j], 5'h00, j == 2);
        repeat (20)
            run(op_kind_t'($urandom % 2), 3'($urandom), 5'($urandom), 5'($urandom), 1'b0);
        foreach (bad[b]) begin
            i_seq.start(bad[b], 5'h00);
            @(negedge i_clk_sys);
            `CHECK("code refused", 1'b0, o_busy);
        end
        repeat (30) @(negedge i_clk_sys);
        give_verdict();
    end

    initial begin
        #(32 * 40 * 10 * 5);
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
